// >>> shared/csreg_pkg.sv
// Package for the command status register block.
// Assumes one core clock and the documented register port of the device.
package csreg_pkg;

  // ************************************************************
  // Field positions of the 32-bit command status register
  // ************************************************************
  localparam int unsigned CSREG_FAMILY_LSB  = 26;
  localparam int unsigned CSREG_LAUNCH_BIT  = 25;
  localparam int unsigned CSREG_CANCEL_BIT  = 24;
  localparam int unsigned CSREG_BURST_LSB   = 8;
  localparam int unsigned CSREG_VALID_BIT   = 7;
  localparam int unsigned CSREG_READY_BIT   = 6;
  localparam int unsigned CSREG_EXEC_BIT    = 5;
  localparam int unsigned CSREG_RESP_BIT    = 4;
  localparam int unsigned CSREG_EXPECT_BIT  = 3;
  localparam int unsigned CSREG_SELFT_BIT   = 2;
  localparam int unsigned CSREG_RESEND_BIT  = 1;

  // Writable trigger fields, checked for exactly one set bit
  localparam logic [31:0] CSREG_TRIG_MASK   = 32'h0300_0062;

  // Localities allowed to reset the launch-history flag
  localparam logic [2:0]  CSREG_LOC_LAUNCH_A = 3'h3;
  localparam logic [2:0]  CSREG_LOC_LAUNCH_B = 3'h4;

  // Reset values
  localparam logic [31:0] CSREG_RD_RST      = 32'h0000_0000;
  localparam logic [15:0] CSREG_BURST_RST   = 16'h0000;
  localparam logic        CSREG_FLAG_RST    = 1'b0;

  // ************************************************************
  // Command state machine
  // ************************************************************
  typedef enum logic [2:0] {
    CSREG_IDLE      = 3'b000,
    CSREG_READY     = 3'b001,
    CSREG_RECEPTION = 3'b010,
    CSREG_EXECUTION = 3'b011,
    CSREG_COMPLETE  = 3'b100
  } csreg_state_t;

  // Host write request, valid for one cycle
  typedef struct packed {
    logic        req;
    logic [2:0]  locality;
    logic [31:0] data;
  } csreg_wr_t;

  // Live status fields gathered from the core
  typedef struct packed {
    logic [1:0]  family;
    logic [15:0] burst;
    logic        sts_valid;
    logic        ready;
    logic        resp_pending;
    logic        expect_more;
    logic        selftest;
  } csreg_status_t;

  // One-cycle trigger pulses toward the command engine
  typedef struct packed {
    logic ready;
    logic execute;
    logic cancel;
    logic resend;
    logic launch_reset;
  } csreg_trig_t;

endpackage

// >>> core/csreg_read_port.sv
// Read side of the command status register: packs fields, inserts wait states.
// Assumes the host holds i_rd_req until it sees the o_rd_ack pulse.
`timescale 1ns/1ps
module csreg_read_port
  import csreg_pkg::*;
(
  input  wire logic          i_core_clk,
  input  wire logic          i_rst_b,
  input  wire logic          i_rd_req,
  input  wire logic          i_settled,
  input  wire csreg_status_t i_status,
  output logic               o_rd_ack,
  output logic [31:0]        o_rd_data
);

  // ************************************************************
  // Field packing
  // ************************************************************
  // Reserved bits and all triggers but ready read as zero
  logic [31:0] packed_w;
  logic        take_w;
  assign packed_w = {4'h0, i_status.family, 2'h0, i_status.burst,
                     i_status.sts_valid, i_status.ready, 1'b0,
                     i_status.resp_pending, i_status.expect_more,
                     i_status.selftest, 1'b0, 1'b0};
  // Stretch the read until the fields are settled
  assign take_w   = i_rd_req && i_settled && !o_rd_ack;

  // Ack and data registers
  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_rd_ack  <= 1'b0;
      o_rd_data <= CSREG_RD_RST;
    end else begin
      o_rd_ack  <= take_w;
      if (take_w) begin
        o_rd_data <= packed_w;
      end
    end
  end

  a_rd_wait_settle : assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
    o_rd_ack |-> $past(i_settled) && $past(i_rd_req))
    else $error("read answered before fields settled");
  a_rd_reserved_zero : assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
    o_rd_ack |-> (o_rd_data & 32'hf300_0023) == 32'h0)
    else $error("reserved or trigger bit read as one");

endmodule

// >>> core/csreg_command_status.sv
// Command status register with its command state machine.
// Assumes synchronous host register port and a command engine on the core clock.
`timescale 1ns/1ps
module csreg_command_status
  import csreg_pkg::*;
(
  input  wire logic          i_core_clk,
  input  wire logic          i_rst_b,
  input  wire logic          i_family_sel,
  input  wire csreg_wr_t     i_wr,
  input  wire logic          i_rd_req,
  input  wire logic [15:0]   i_burst,
  input  wire logic          i_burst_settled,
  input  wire logic          i_first_byte,
  input  wire logic          i_expect_more,
  input  wire logic          i_expect_valid,
  input  wire logic          i_resp_avail,
  input  wire logic          i_resp_valid,
  input  wire logic          i_selftest_done,
  output logic               o_rd_ack,
  output logic [31:0]        o_rd_data,
  output csreg_trig_t        o_trig,
  output csreg_state_t       o_state
);

  // ************************************************************
  // Helpers
  // ************************************************************
  // Number of trigger fields set in a write word
  function automatic logic [2:0] csreg_ones(input logic [31:0] w);
    logic [2:0] n;
    n = 3'h0;
    for (int i = 0; i < 32; i++) begin
      if (CSREG_TRIG_MASK[i] && w[i]) begin
        n = (n == 3'h7) ? n : 3'(n + 3'h1);
      end
    end
    return n;
  endfunction

  // ************************************************************
  // Write decode
  // ************************************************************
  logic        one_hot_w;
  logic        wr_ready_w;
  logic        wr_exec_w;
  logic        wr_cancel_w;
  logic        wr_resend_w;
  logic        wr_launch_w;
  logic        loc_ok_w;
  csreg_state_t state_q;
  csreg_state_t state_d;

  // Only a write with exactly one field at one acts
  assign one_hot_w   = i_wr.req && (csreg_ones(i_wr.data) == 3'h1);
  assign wr_ready_w  = one_hot_w && i_wr.data[CSREG_READY_BIT];
  assign wr_exec_w   = one_hot_w && i_wr.data[CSREG_EXEC_BIT];
  assign wr_cancel_w = one_hot_w && i_wr.data[CSREG_CANCEL_BIT];
  assign wr_resend_w = one_hot_w && i_wr.data[CSREG_RESEND_BIT];
  assign wr_launch_w = one_hot_w && i_wr.data[CSREG_LAUNCH_BIT];
  assign loc_ok_w    = (i_wr.locality == CSREG_LOC_LAUNCH_A) ||
                       (i_wr.locality == CSREG_LOC_LAUNCH_B);

  // ************************************************************
  // Command state machine
  // ************************************************************
  always_comb begin
    state_d = state_q;
    case (state_q)
      CSREG_IDLE: begin
        if (wr_ready_w) begin
          state_d = CSREG_READY;
        end
      end
      CSREG_READY: begin
        if (i_first_byte) begin
          state_d = CSREG_RECEPTION;
        end
      end
      CSREG_RECEPTION: begin
        if (wr_ready_w) begin
          state_d = CSREG_IDLE;
        end else if (wr_exec_w) begin
          state_d = CSREG_EXECUTION;
        end
      end
      CSREG_EXECUTION: begin
        if (wr_ready_w) begin
          state_d = CSREG_IDLE;
        end else if (i_resp_avail) begin
          state_d = CSREG_COMPLETE;
        end
      end
      CSREG_COMPLETE: begin
        if (wr_ready_w) begin
          state_d = CSREG_IDLE;
        end
      end
      default: begin
        state_d = CSREG_IDLE;
      end
    endcase
  end

  // State register
  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      state_q <= CSREG_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // ************************************************************
  // Trigger pulses
  // ************************************************************
  csreg_trig_t trig_d;
  logic        idle_rdy_w;
  assign idle_rdy_w          = (state_q == CSREG_IDLE) || (state_q == CSREG_READY);
  assign trig_d.ready        = wr_ready_w;
  assign trig_d.execute      = wr_exec_w && (state_q == CSREG_RECEPTION);
  assign trig_d.cancel       = wr_cancel_w && (state_q == CSREG_EXECUTION);
  assign trig_d.resend       = wr_resend_w && (state_q == CSREG_COMPLETE);
  assign trig_d.launch_reset = wr_launch_w && loc_ok_w && idle_rdy_w;

  // Pulses last one cycle and nothing is kept
  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_trig  <= '0;
      o_state <= CSREG_IDLE;
    end else begin
      o_trig  <= trig_d;
      o_state <= state_d;
    end
  end

  // ************************************************************
  // Status fields
  // ************************************************************
  logic          fam_seen_q;
  logic          fam_q;
  logic [15:0]   burst_q;
  logic          valid_q;
  logic          resp_q;
  logic          expect_q;
  logic          selft_q;
  csreg_status_t status_w;

  // Family strap caught once after reset release
  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      fam_seen_q <= CSREG_FLAG_RST;
      fam_q      <= CSREG_FLAG_RST;
    end else if (!fam_seen_q) begin
      fam_seen_q <= 1'b1;
      fam_q      <= i_family_sel;
    end
  end

  // Live fields sampled each cycle
  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      burst_q  <= CSREG_BURST_RST;
      valid_q  <= CSREG_FLAG_RST;
      resp_q   <= CSREG_FLAG_RST;
      expect_q <= CSREG_FLAG_RST;
      selft_q  <= CSREG_FLAG_RST;
    end else begin
      burst_q  <= i_burst;
      valid_q  <= i_expect_valid && i_resp_valid;
      resp_q   <= i_resp_avail;
      expect_q <= i_expect_more;
      selft_q  <= i_selftest_done;
    end
  end

  assign status_w.family       = {1'b0, fam_q};
  assign status_w.burst        = burst_q;
  assign status_w.sts_valid    = valid_q;
  assign status_w.ready        = (state_q == CSREG_READY);
  assign status_w.resp_pending = resp_q;
  assign status_w.expect_more  = expect_q;
  assign status_w.selftest     = selft_q;

  // Read port with wait states
  csreg_read_port u_read (
    .i_core_clk (i_core_clk),
    .i_rst_b    (i_rst_b),
    .i_rd_req   (i_rd_req),
    .i_settled  (i_burst_settled && fam_seen_q),
    .i_status   (status_w),
    .o_rd_ack   (o_rd_ack),
    .o_rd_data  (o_rd_data)
  );

  // ************************************************************
  // Checks
  // ************************************************************
  a_multi_field_drop : assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
    (i_wr.req && csreg_ones(i_wr.data) > 3'h1 && !i_first_byte && !i_resp_avail)
      |=> (o_trig == '0)
      && $stable(o_state))
    else $error("multi-field write acted");
  a_cancel_gate : assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
    o_trig.cancel |-> $past(state_q) == CSREG_EXECUTION)
    else $error("cancel pulsed outside execution");
  a_cancel_ignored : assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
    (state_q == CSREG_COMPLETE && wr_cancel_w) |=> !o_trig.cancel)
    else $error("cancel acted after response");
  a_launch_locality : assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
    o_trig.launch_reset |-> $past(i_wr.locality) inside {3'h3, 3'h4})
    else $error("launch flag reset from wrong locality");
  a_trig_single : assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
    o_trig.execute |=> !o_trig.execute)
    else $error("trigger held longer than one cycle");
  a_exec_moves : assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
    (state_q == CSREG_RECEPTION && wr_exec_w && !wr_ready_w)
      |=> state_q == CSREG_EXECUTION ##0 o_trig.execute)
    else $error("execute did not start command");
  a_ready_moves : assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
    (state_q == CSREG_IDLE && wr_ready_w)
      |=> state_q == CSREG_READY && o_trig.ready)
    else $error("ready write did not move state");
  a_valid_ties : assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
    status_w.sts_valid |-> $past(i_expect_valid) && $past(i_resp_valid))
    else $error("status valid without valid fields");
  a_family_legal : assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
    o_rd_ack |-> !o_rd_data[CSREG_FAMILY_LSB + 1])
    else $error("reserved family code reported");

  c_full_command : cover property (@(posedge i_core_clk) disable iff (!i_rst_b)
    state_q == CSREG_EXECUTION ##[1:50] state_q == CSREG_COMPLETE);
  c_cancel_run : cover property (@(posedge i_core_clk) disable iff (!i_rst_b)
    o_trig.cancel);
  c_resend : cover property (@(posedge i_core_clk) disable iff (!i_rst_b)
    o_trig.resend);
  c_launch : cover property (@(posedge i_core_clk) disable iff (!i_rst_b)
    o_trig.launch_reset);

endmodule

// >>> dv/csreg_engine_model.sv
// Model of the command engine and FIFO that sit behind the status register.
// Assumes the design's trigger pulses and state, all on the core clock.
`timescale 1ns/1ps
module csreg_engine_model
  import csreg_pkg::*;
(
  input  wire logic         i_core_clk,
  input  wire logic         i_rst_b,
  input  wire csreg_trig_t  i_trig,
  input  wire csreg_state_t i_state,
  output logic [15:0]       o_burst,
  output logic              o_settled,
  output logic              o_expect_more,
  output logic              o_expect_valid,
  output logic              o_resp_avail,
  output logic              o_resp_valid,
  output logic              o_selftest_done
);
  logic [3:0] busy_q;
  logic [3:0] rcv_q;
  logic [2:0] resp_q;
  logic [5:0] st_q;
  wire        in_rcv = (i_state == CSREG_RECEPTION);

  // ****************************************
  // Status fields seen by the register
  // ****************************************
  // Fields stay unsettled for a while after any trigger, so reads must wait
  assign o_settled       = (busy_q == 4'h0);
  assign o_expect_more   = in_rcv && (rcv_q < 4'hc);
  assign o_expect_valid  = 1'b1;
  assign o_resp_valid    = (busy_q == 4'h0);
  assign o_burst         = in_rcv ? 16'h0040 : {11'h000, o_resp_avail, 4'h0};
  assign o_selftest_done = (st_q == 6'h28);

  // ****************************************
  // Engine timing on the falling edge
  // ****************************************
  // Execute or cancel yields a response a few cycles later, ready frees it
  always_ff @(negedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      busy_q       <= 4'h0;
      rcv_q        <= 4'h0;
      resp_q       <= 3'h0;
      st_q         <= 6'h00;
      o_resp_avail <= 1'b0;
    end else begin
      busy_q <= (|i_trig) ? 4'h8 : busy_q - {3'h0, (busy_q != 4'h0)};
      rcv_q  <= !in_rcv ? 4'h0 : rcv_q + {3'h0, (rcv_q != 4'hc)};
      st_q   <= st_q + {5'h00, (st_q != 6'h28)};
      resp_q <= (i_trig.execute || i_trig.cancel) ? 3'h4 : resp_q - {2'h0, (resp_q != 3'h0)};
      if (i_trig.ready) begin
        o_resp_avail <= 1'b0;
      end else if (resp_q == 3'h1) begin
        o_resp_avail <= 1'b1;
      end
    end
  end
endmodule

// >>> dv/tb_top.sv
// Self-checking bench for the command status register.
// Assumes the engine model on the far side and host accesses at the falling edge.
`timescale 1ns/1ps
module tb_top
  import csreg_pkg::*;
  ;
  logic         i_core_clk;
  logic         i_rst_b;
  logic         i_family_sel;
  csreg_wr_t    i_wr;
  logic         i_rd_req;
  logic         i_first_byte;
  logic [15:0]  burst;
  logic         settled, exp_more, exp_valid, resp, resp_valid, selftest;
  logic         o_rd_ack;
  logic [31:0]  o_rd_data;
  csreg_trig_t  o_trig;
  csreg_state_t o_state;
  int           errors, compares, cycles, ws;

  csreg_command_status csreg_command_status_i (
    .i_core_clk(i_core_clk), .i_rst_b(i_rst_b), .i_family_sel(i_family_sel), .i_wr(i_wr),
    .i_rd_req(i_rd_req), .i_burst(burst), .i_burst_settled(settled),
    .i_first_byte(i_first_byte), .i_expect_more(exp_more), .i_expect_valid(exp_valid),
    .i_resp_avail(resp), .i_resp_valid(resp_valid), .i_selftest_done(selftest),
    .o_rd_ack(o_rd_ack), .o_rd_data(o_rd_data), .o_trig(o_trig), .o_state(o_state));

  csreg_engine_model csreg_engine_model_i (
    .i_core_clk(i_core_clk), .i_rst_b(i_rst_b), .i_trig(o_trig), .i_state(o_state),
    .o_burst(burst), .o_settled(settled), .o_expect_more(exp_more),
    .o_expect_valid(exp_valid), .o_resp_avail(resp), .o_resp_valid(resp_valid),
    .o_selftest_done(selftest));

  // ****************************************
  // Clock, timeout and helpers
  // ****************************************
  initial begin
    i_core_clk = 1'b0;
    forever #50 i_core_clk = ~i_core_clk;
  end

  // Cut a hang short well beyond the roughly 130 cycles the tests need
  always @(posedge i_core_clk) begin
    cycles++;
    if (cycles == 3000) begin
      errors++;
      complete_run();
    end
  end

  task automatic complete_run();
    $display("errors=%0d compares=%0d", errors, compares);
    if (errors == 0 && compares > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      errors++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // Engine fields as the register saw them: one edge into the status flops, one into the read
  logic [19:0] eng_q;
  logic [19:0] eng_rd_q;
  always @(posedge i_core_clk) begin
    eng_q    <= {burst, exp_valid & resp_valid, resp, exp_more, selftest};
    eng_rd_q <= eng_q;
  end

  // Expected read word built from the engine's fields and the strap
  function automatic logic [31:0] exp_rd(input logic rdy);
    return {4'h0, 1'b0, i_family_sel, 2'b00, eng_rd_q[19:4], eng_rd_q[3], rdy, 1'b0,
            eng_rd_q[2:0], 2'b00};
  endfunction

  // One host write, then the trigger pulse and state are checked
  task automatic wr(input logic [2:0] loc, input logic [31:0] d, input logic [4:0] t,
                    input csreg_state_t s);
    @(negedge i_core_clk);
    i_wr = '{req: 1'b1, locality: loc, data: d};
    @(negedge i_core_clk);
    i_wr.req = 1'b0;
    chk({27'h0, o_trig}, {27'h0, t});
    chk({29'h0, o_state}, {29'h0, s});
    @(negedge i_core_clk);
    chk({27'h0, o_trig}, 32'h0);
  endtask

  // One host read, held until the answer, with the wait counted in ws
  task automatic rd(input logic rdy);
    ws = 0;
    @(negedge i_core_clk);
    i_rd_req = 1'b1;
    do begin
      @(negedge i_core_clk);
      ws++;
    end while (o_rd_ack !== 1'b1 && ws < 200);
    i_rd_req = 1'b0;
    chk({31'h0, o_rd_ack}, 32'h1);
    chk(o_rd_data, exp_rd(rdy));
  endtask

  // ****************************************
  // Test sequence
  // ****************************************
  initial begin
    errors = 0;
    compares = 0;
    cycles = 0;
    i_rst_b = 1'b0;
    i_family_sel = 1'b1;
    i_wr = '0;
    i_rd_req = 1'b0;
    i_first_byte = 1'b0;
    repeat (16) @(negedge i_core_clk);
    i_rst_b = 1'b1;
    rd(1'b0);
    wr(3'h0, 32'h0000_0000, 5'h00, CSREG_IDLE);
    wr(3'h0, 32'h0000_0060, 5'h00, CSREG_IDLE);
    wr(3'h2, 32'h0200_0000, 5'h00, CSREG_IDLE);
    wr(3'h3, 32'h0200_0000, 5'h01, CSREG_IDLE);
    wr(3'h0, 32'h0000_0040, 5'h10, CSREG_READY);
    wr(3'h4, 32'h0200_0000, 5'h01, CSREG_READY);
    wr(3'h0, 32'h0000_0020, 5'h00, CSREG_READY);
    wr(3'h0, 32'h0100_0000, 5'h00, CSREG_READY);
    wr(3'h0, 32'h0000_0002, 5'h00, CSREG_READY);
    repeat (10) @(negedge i_core_clk);
    rd(1'b1);
    @(negedge i_core_clk);
    i_first_byte = 1'b1;
    @(negedge i_core_clk);
    i_first_byte = 1'b0;
    rd(1'b0);
    chk({31'h0, o_rd_data[3]}, 32'h1);
    wr(3'h3, 32'h0200_0000, 5'h00, CSREG_RECEPTION);
    repeat (12) @(negedge i_core_clk);
    rd(1'b0);
    chk({31'h0, o_rd_data[3]}, 32'h0);
    wr(3'h0, 32'h0000_0020, 5'h08, CSREG_EXECUTION);
    wr(3'h0, 32'h0100_0000, 5'h04, CSREG_EXECUTION);
    rd(1'b0);
    chk({31'h0, ws > 3}, 32'h1);
    chk({31'h0, o_rd_data[7]}, 32'h0);
    chk({31'h0, o_rd_data[4]}, 32'h1);
    chk({29'h0, o_state}, {29'h0, CSREG_COMPLETE});
    wr(3'h0, 32'h0100_0000, 5'h00, CSREG_COMPLETE);
    wr(3'h0, 32'h0000_0002, 5'h02, CSREG_COMPLETE);
    wr(3'h0, 32'h0000_0020, 5'h00, CSREG_COMPLETE);
    wr(3'h0, 32'h0000_0040, 5'h10, CSREG_IDLE);
    repeat (12) @(negedge i_core_clk);
    rd(1'b0);
    chk({30'h0, o_rd_data[4], o_rd_data[2]}, 32'h1);
    wr(3'h0, 32'h0000_0040, 5'h10, CSREG_READY);
    @(negedge i_core_clk);
    i_first_byte = 1'b1;
    @(negedge i_core_clk);
    i_first_byte = 1'b0;
    wr(3'h0, 32'h0000_0040, 5'h10, CSREG_IDLE);
    complete_run();
  end
endmodule
